// File: pkg/slic_pkg.sv
// Constants and carrier types for the status indicator controller.
// Assumes a single 250 MHz system clock shared by all event sources.
package slic_pkg;

  // ********************************************************************
  // Sizes and timing
  // ********************************************************************
  localparam int unsigned SLIC_NUM_PHASES = 3;
  localparam int unsigned SLIC_NUM_IND = 5;
  localparam int unsigned SLIC_CLK_MHZ = 250;
  localparam int unsigned SLIC_FLASH_MS = 50;
  localparam int unsigned SLIC_FLASH_CYC = SLIC_FLASH_MS * 1000 * SLIC_CLK_MHZ;
  localparam int unsigned SLIC_CNT_W = 24;

  // ********************************************************************
  // Carrier types
  // ********************************************************************
  typedef struct packed {
    logic red;
    logic green;
  } slic_led_t;

  typedef struct packed {
    logic rx;
    logic tx;
  } slic_evt_t;

  typedef enum logic [1:0] {
    SLIC_ST_TEST = 2'b00,
    SLIC_ST_PASS = 2'b01,
    SLIC_ST_FAIL = 2'b11
  } slic_diag_t;

endpackage : slic_pkg

// File: verilog/slic_flash.sv
// One bicolor activity channel: stretches rx and tx events into flashes.
// Assumes events are single-cycle or level pulses synchronous to sys_clk.
`timescale 1ns/1ns
module slic_flash #(
  parameter logic [slic_pkg::SLIC_CNT_W-1:0] FLASH_LEN = 24'd16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Events and override
  input wire slic_pkg::slic_evt_t evt,
  input wire logic fault,
  // Indicator drive
  output slic_pkg::slic_led_t led
);
  import slic_pkg::*;

  logic [SLIC_CNT_W-1:0] cnt_q;
  logic is_tx_q;

  // ********************************************************************
  // Flash stretcher
  // ********************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      is_tx_q <= 1'b0;
    end else if (evt.tx) begin
      cnt_q <= FLASH_LEN;
      is_tx_q <= 1'b1;
    end else if (evt.rx) begin
      cnt_q <= FLASH_LEN;
      is_tx_q <= 1'b0;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // ********************************************************************
  // Output with fault override
  // ********************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      led <= '0;
    end else if (fault) begin
      led <= '{red: 1'b1, green: 1'b0};
    end else if (evt.tx) begin
      led <= '{red: 1'b1, green: 1'b0};
    end else if (evt.rx) begin
      led <= '{red: 1'b0, green: 1'b1};
    end else if (cnt_q > 1) begin
      led <= '{red: is_tx_q, green: !is_tx_q};
    end else begin
      led <= '0;
    end
  end

  a_tx_wins: assert property (@(posedge sys_clk) disable iff (rst)
    (evt.tx && !fault) |=> (led.red && !led.green))
    else $error("tx event did not light red");
  a_rx_green: assert property (@(posedge sys_clk) disable iff (rst)
    (evt.rx && !evt.tx && !fault) |=> (led.green && !led.red))
    else $error("rx event did not light green");
  a_fault_red: assert property (@(posedge sys_clk) disable iff (rst)
    fault |=> (led.red && !led.green))
    else $error("fault did not hold red");
  a_flash_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (evt.tx && !fault) ##1 (!evt.tx && !evt.rx && !fault) |=> (led.red || fault))
    else $error("flash ended early");

endmodule : slic_flash

// File: verilog/slic_top.sv
// Status indicator controller: five bicolor indicators.
// Assumes event, fault and self-test inputs are synchronous to sys_clk.
// Notes on behaviour
// - Five bicolor indicators: phases one to three, serial and diagnostic.
// - Phase carrier detect or decoded message flashes that phase green.
// - Phase message sent flashes that phase red.
// - Serial message received, either standard, flashes serial indicator green.
// - Serial message sent, either standard, flashes serial indicator red.
// - Self-test running holds diagnostic indicator steady yellow.
// - Self-test failure switches diagnostic indicator to steady red.
// - Self-test success switches diagnostic indicator to steady green.
// - Failed phase communication holds that phase indicator steady red.
`timescale 1ns/1ns
module slic_top #(
  parameter logic [slic_pkg::SLIC_CNT_W-1:0] FLASH_LEN =
    slic_pkg::SLIC_CNT_W'(slic_pkg::SLIC_FLASH_CYC)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Power line events per phase
  input wire slic_pkg::slic_evt_t [slic_pkg::SLIC_NUM_PHASES-1:0] pl_evt,
  input wire logic [slic_pkg::SLIC_NUM_PHASES-1:0] pl_fault,
  // Serial events
  input wire slic_pkg::slic_evt_t ser_evt,
  // Self-test status
  input wire logic test_done,
  input wire logic test_pass,
  // Indicator drive
  output slic_pkg::slic_led_t [slic_pkg::SLIC_NUM_IND-1:0] led
);
  import slic_pkg::*;

  slic_diag_t diag_q;
  slic_led_t [SLIC_NUM_IND-2:0] act_led;
  slic_led_t diag_led_q;

  // Single driver for the whole output array
  assign led = {diag_led_q, act_led};

  // ********************************************************************
  // Activity channels
  // ********************************************************************
  genvar g;
  generate
    for (g = 0; g < SLIC_NUM_PHASES; g++) begin : g_phase
      slic_flash #(.FLASH_LEN(FLASH_LEN)) u_phase (
        .sys_clk(sys_clk),
        .rst(rst),
        .evt(pl_evt[g]),
        .fault(pl_fault[g]),
        .led(act_led[g])
      );
    end
  endgenerate

  slic_flash #(.FLASH_LEN(FLASH_LEN)) u_serial (
    .sys_clk(sys_clk),
    .rst(rst),
    .evt(ser_evt),
    .fault(1'b0),
    .led(act_led[SLIC_NUM_PHASES])
  );

  // ********************************************************************
  // Self-test state
  // ********************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      diag_q <= SLIC_ST_TEST;
    end else begin
      case (diag_q)
        SLIC_ST_TEST: begin
          if (test_done) begin
            diag_q <= test_pass ? SLIC_ST_PASS : SLIC_ST_FAIL;
          end
        end
        default: begin
          diag_q <= diag_q;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      diag_led_q <= '0;
    end else begin
      case (diag_q)
        SLIC_ST_TEST: diag_led_q <= '{red: 1'b1, green: 1'b1};
        SLIC_ST_FAIL: diag_led_q <= '{red: 1'b1, green: 1'b0};
        default: diag_led_q <= '{red: 1'b0, green: 1'b1};
      endcase
    end
  end

  a_test_yellow: assert property (@(posedge sys_clk) disable iff (rst)
    (diag_q == SLIC_ST_TEST) ##1 (diag_q == SLIC_ST_TEST) |->
    (led[SLIC_NUM_IND-1].red && led[SLIC_NUM_IND-1].green))
    else $error("self-test not yellow");
  a_fail_red: assert property (@(posedge sys_clk) disable iff (rst)
    (diag_q == SLIC_ST_TEST && test_done && !test_pass) |=> ##1
    (led[SLIC_NUM_IND-1].red && !led[SLIC_NUM_IND-1].green))
    else $error("failed self-test not red");
  a_pass_green: assert property (@(posedge sys_clk) disable iff (rst)
    (diag_q == SLIC_ST_TEST && test_done && test_pass) |=> ##1
    (led[SLIC_NUM_IND-1].green && !led[SLIC_NUM_IND-1].red))
    else $error("passed self-test not green");
  a_result_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    (diag_q != SLIC_ST_TEST) |=> $stable(diag_q))
    else $error("self-test result changed");
  a_phase_fault: assert property (@(posedge sys_clk) disable iff (rst)
    pl_fault[0] |=> (led[0].red && !led[0].green))
    else $error("phase fault not red");
  a_ser_tx: assert property (@(posedge sys_clk) disable iff (rst)
    ser_evt.tx |=> led[SLIC_NUM_PHASES].red)
    else $error("serial tx not red");
  a_ser_rx: assert property (@(posedge sys_clk) disable iff (rst)
    (ser_evt.rx && !ser_evt.tx) |=> led[SLIC_NUM_PHASES].green)
    else $error("serial rx not green");
  a_phase_tx: assert property (@(posedge sys_clk) disable iff (rst)
    (pl_evt[1].tx && !pl_fault[1]) |=> (led[1].red && !led[1].green))
    else $error("phase tx not red");

endmodule : slic_top

// File: bench/slic_src_model.sv
// Event source model: maps a bench pick word onto power line and serial pulses.
// Assumes the pick word changes only at the falling edge of sys_clk.
`timescale 1ns/1ns
module slic_src_model (
  // Request from bench
  input wire logic [7:0] pick,
  // Event pulses
  output slic_pkg::slic_evt_t [slic_pkg::SLIC_NUM_PHASES-1:0] pl_evt,
  output slic_pkg::slic_evt_t ser_evt
);
  import slic_pkg::*;
  assign pl_evt = pick[5:0];
  assign ser_evt = pick[7:6];
endmodule : slic_src_model

// File: bench/slic_top_tb_top.sv
// Testbench: random events against a cycle model of all five indicators.
// Assumes slic_top with FLASH_LEN shortened to 16 cycles.
`timescale 1ns/1ns
module slic_top_tb_top;
  import slic_pkg::*;
  localparam logic [SLIC_CNT_W-1:0] FL = 24'h000010;
  logic sys_clk, rst, test_done, test_pass;
  logic [2:0] pl_fault;
  logic [7:0] pick;
  slic_evt_t [SLIC_NUM_PHASES-1:0] pl_evt;
  slic_evt_t ser_evt, ev;
  slic_led_t [SLIC_NUM_IND-1:0] led, exp_led;
  int error_cnt, check_count, cyc;
  int cnt[4];
  logic [1:0] col[4];
  slic_diag_t diag;
  logic locked;
  `define CHK(A, E) begin check_count++; if ((A) !== (E)) begin error_cnt++; \
    $display("BAD %0t led %h exp %h", $time, A, E); end end
  slic_src_model src (.pick(pick), .pl_evt(pl_evt), .ser_evt(ser_evt));
  slic_top #(.FLASH_LEN(FL)) dut (.sys_clk(sys_clk), .rst(rst), .pl_evt(pl_evt),
    .pl_fault(pl_fault), .ser_evt(ser_evt), .test_done(test_done),
    .test_pass(test_pass), .led(led));
  // ******************************************************************
  // Clock, model and compare
  // ******************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      exp_led = '0;
      diag = SLIC_ST_TEST;
      locked = 1'b0;
      for (int i = 0; i < 4; i++) cnt[i] = 0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        ev = (i < 3) ? pl_evt[i] : ser_evt;
        if (ev != 2'b00) begin
          cnt[i] = int'(FL);
          col[i] = ev.tx ? 2'b10 : 2'b01;
          exp_led[i] = col[i];
        end else begin
          exp_led[i] = (cnt[i] > 1) ? col[i] : 2'b00;
          if (cnt[i] > 0) cnt[i]--;
        end
        if (i < 3 && pl_fault[i]) exp_led[i] = 2'b10;
      end
      exp_led[4] = (diag == SLIC_ST_TEST) ? 2'b11 : (diag == SLIC_ST_PASS) ? 2'b01 : 2'b10;
      if (test_done && !locked) begin
        diag = test_pass ? SLIC_ST_PASS : SLIC_ST_FAIL;
        locked = 1'b1;
      end
    end
  end
  always @(negedge sys_clk) begin
    if (!rst) begin
      for (int i = 0; i < 3; i++) `CHK(led[i], exp_led[i])
      `CHK(led[3], exp_led[3])
      `CHK(led[4], exp_led[4])
    end
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ******************************************************************
  // Tasks and sequence
  // ******************************************************************
  task automatic run(input int n, input int dens);
    for (int k = 0; k < n; k++) begin
      @(negedge sys_clk);
      test_done = 1'b0;
      pick = (($urandom % 8) < dens) ? 8'($urandom) : 8'h00;
    end
  endtask : run
  task automatic done_pulse(input logic pass);
    @(negedge sys_clk);
    test_done = 1'b1;
    test_pass = pass;
    run(20, 0);
  endtask : done_pulse
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial begin
    rst = 1'b1;
    pick = 8'h00;
    pl_fault = 3'h0;
    test_done = 1'b0;
    test_pass = 1'b0;
    void'($urandom(32'hfc8a));
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    run(400, 2);
    run(200, 7);
    $display("Test activity ended");
    for (int j = 0; j < 8; j++) begin
      pl_fault = 3'($urandom);
      run(40, 4);
    end
    pl_fault = 3'h0;
    run(60, 3);
    $display("Test fault ended");
    done_pulse(1'b0);
    done_pulse(1'b1);
    rst = 1'b1;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    done_pulse(1'b1);
    done_pulse(1'b0);
    $display("Test self check ended");
    end_sim();
  end
endmodule : slic_top_tb_top
